// ### dv/pwm_dual_properties.sv
// Checker on the dual modulator ports, channel one in depth.
// Assumes one clock domain; bound after the module.
`timescale 1ns/1ps
`default_nettype none
module pwm_dual_checker (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rdata,
    input wire logic [7:0] timer2_count,
    input wire logic [1:0] timer2_frac,
    input wire logic [7:0] timer2_period,
    input wire logic timer2_clear,
    input wire logic timer4_clear,
    input wire logic [1:0] pwm_level,
    input wire logic [1:0] primary_pin_out,
    input wire logic [1:0] primary_pin_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic en_r, pol_r, sel_r;
    logic [9:0] duty_r, buf_r;
    wire logic clr0 = sel_r ? timer4_clear : timer2_clear;
    wire logic lvl_bit = en_r & pwm_level[0];
    // Shadow of control, select and buffered duty
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            {en_r, pol_r, sel_r, buf_r} <= '0;
        end else begin
            if (wr_stb && addr == 4'h0) {en_r, pol_r} <= {wdata[7], wdata[4]};
            if (wr_stb && addr == 4'h8) sel_r <= wdata[0];
            if (clr0) buf_r <= duty_r;
        end
    end
    // Duty shadow survives reset_n
    always_ff @(posedge mclk) begin
        if (wr_stb && addr == 4'h2) duty_r[9:2] <= wdata;
        if (wr_stb && addr == 4'h3) duty_r[1:0] <= wdata[7:6];
    end
    sequence restart_s;
        en_r && clr0 && !wr_stb;
    endsequence
    sequence quiet_s;
        (!wr_stb) [*4];
    endsequence
    restart_set_a: assert property (
        restart_s ##0 (duty_r != 10'h000) |=> pwm_level[0] != pol_r)
        else $error("not active after restart");
    zero_duty_a: assert property (
        restart_s ##0 (duty_r == 10'h000) |=> pwm_level[0] == pol_r)
        else $error("zero duty went active");
    match_clear_a: assert property (
        en_r && !sel_r && !timer2_clear && !wr_stb &&
        {timer2_count, timer2_frac} == buf_r |=> pwm_level[0] == pol_r)
        else $error("not cleared at duty match");
    full_duty_a: assert property (
        restart_s ##0 (!sel_r && duty_r > {timer2_period, 2'b11}) ##1 quiet_s
        |-> pwm_level[0] != pol_r) else $error("full duty cleared");
    disabled_level_a: assert property (
        !en_r && $stable(en_r) |-> pwm_level[0] == pol_r)
        else $error("disabled level wrong");
    level_bit_a: assert property (
        rd_stb && addr == 4'h0 |=> rdata[5] == $past(lvl_bit))
        else $error("level bit wrong");
    primary_pin_a: assert property (
        primary_pin_oe[0] |-> primary_pin_out[0] == $past(pwm_level[0]))
        else $error("primary pin wrong");
    oe_follow_a: assert property (
        wr_stb && addr == 4'h0 ##1 !(wr_stb && addr == 4'h0)
        |=> primary_pin_oe[0] == $past(wdata[6], 2))
        else $error("primary enable wrong");
    duty_low_a: assert property (
        rd_stb && addr == 4'h3 |=> rdata[5:0] == 6'h00)
        else $error("low duty spare bits set");
    second_pin_a: assert property (
        primary_pin_oe[1] |-> primary_pin_out[1] == $past(pwm_level[1]))
        else $error("second primary pin wrong");
endmodule
bind pwm_dual pwm_dual_checker i_pwm_dual_checker (.mclk, .reset_n, .addr,
    .wdata, .wr_stb, .rd_stb, .rdata, .timer2_count, .timer2_frac,
    .timer2_period, .timer2_clear, .timer4_clear, .pwm_level,
    .primary_pin_out, .primary_pin_oe);
`default_nettype wire

// ### dv/pwm_dual_tb.sv
// Self-checking bench for the dual modulator with two time bases.
// Assumes the checker file is compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module pwm_dual_tb;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic por_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic run = 1'b0;
    logic [7:0] per2 = 8'h03;
    logic [7:0] per4 = 8'h01;
    logic [7:0] rdata, cnt2, cnt4, xpo, xpoe;
    logic [1:0] fr2, fr4, lvl, ppo, ppoe;
    logic clr2, clr4;
    int err_total = 0;
    int checks_done = 0;
    // Duty high, duty low, control, select, expected high count
    logic [39:0] rows [7] = '{40'h01_40c0_0005, 40'h01_40d0_000b,
        40'h00_00c0_0000, 40'h04_00c0_0010, 40'h03_c0c0_000f,
        40'h00_c0c0_0106, 40'h01_4050_0010};
    initial forever #5 mclk = ~mclk;
    pwm_timebase i_timer2 (.mclk(mclk), .run(run), .period(per2),
        .count(cnt2), .frac(fr2), .clear(clr2));
    pwm_timebase i_timer4 (.mclk(mclk), .run(run), .period(per4),
        .count(cnt4), .frac(fr4), .clear(clr4));
    pwm_dual i_pwm_dual (.mclk(mclk), .reset_n(reset_n), .por_n(por_n),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .timer2_count(cnt2), .timer2_frac(fr2),
        .timer2_period(per2), .timer2_clear(clr2), .timer4_count(cnt4),
        .timer4_frac(fr4), .timer4_period(per4), .timer4_clear(clr4),
        .pwm_level(lvl), .primary_pin_out(ppo), .primary_pin_oe(ppoe),
        .extra_pin_out(xpo), .extra_pin_oe(xpoe));
    task automatic check(input logic [7:0] got, input logic [7:0] ex);
        checks_done++;
        if (got !== ex) begin
            err_total++;
            $display("FAIL %0t: got %h expected %h", $time, got, ex);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] ex);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        @(negedge mclk);
        check(rdata, ex);
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Counts high cycles of level and pins over sixteen cycles
    task automatic measure(input int ch, input logic [7:0] ex);
        logic [7:0] nl, np, nx;
        {nl, np, nx} = '0;
        repeat (40) @(posedge mclk);
        repeat (16) begin
            @(negedge mclk);
            nl = nl + 8'(lvl[ch]);
            np = np + 8'(ppo[ch]);
            nx = nx + 8'(xpo[ch * 4 + 3]);
        end
        check(nl, ex);
        check(np, ex);
        check(nx, ex);
    endtask
    task automatic t_regs();
        rd(4'h0, 8'h00);
        rd(4'h8, 8'h00);
        wr(4'h4, 8'he0);
        rd(4'h4, 8'hc0);
        wr(4'h4, 8'hff);
        rd(4'h4, 8'hf0);
        wr(4'h4, 8'h7f);
        rd(4'h4, 8'h50);
        wr(4'h1, 8'hff);
        rd(4'h1, 8'h0f);
        wr(4'h8, 8'hff);
        rd(4'h8, 8'h05);
        wr(4'h3, 8'hff);
        rd(4'h3, 8'hc0);
        wr(4'h2, 8'ha5);
        rd(4'h2, 8'ha5);
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00);
        // Ordinary reset mid-run, driven on the rising edge
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        rd(4'h2, 8'ha5);
        rd(4'h3, 8'hc0);
        rd(4'h1, 8'h00);
    endtask
    task automatic t_setup();
        int i;
        for (i = 0; i < 8; i++) wr(4'(i), 8'h00);
        // pins stay off while only on-chip use
        @(negedge mclk);
        check({6'h00, ppoe}, 8'h00);
        check(xpoe, 8'h00);
        wr(4'h8, 8'h00);
        run <= 1'b1;
        for (i = 0; i < 100 && clr2 !== 1'b1; i++) @(posedge mclk);
        if (clr2 !== 1'b1) begin
            $display("FAIL %0t: timer never overflowed", $time);
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic t_wave();
        logic [7:0] hi, lo, ct, sl, ex;
        for (int ch = 0; ch < 2; ch++) begin
            wr(4'(ch * 4 + 1), 8'h0f);
            for (int i = 0; i < 7; i++) begin
                {hi, lo, ct, sl, ex} = rows[i];
                wr(4'(ch * 4 + 2), hi);
                wr(4'(ch * 4 + 3), lo);
                wr(4'(ch * 4), ct);
                wr(4'h8, sl << (ch * 2));
                measure(ch, ex);
            end
        end
    endtask
    task automatic t_pins();
        wr(4'h2, 8'h04);
        wr(4'h3, 8'h00);
        wr(4'h8, 8'h00);
        wr(4'h0, 8'hc0);
        repeat (40) @(posedge mclk);
        rd(4'h0, 8'he0);
        wr(4'h0, 8'h80);
        rd(4'h3, 8'h00);
        check({6'h00, ppoe}, 8'h02);
        check(xpoe, 8'hff);
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        por_n <= 1'b1;
        t_regs();
        t_setup();
        t_wave();
        t_pins();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ### dv/pwm_timebase.sv
// Time base model of one external 8-bit timer with 2-bit fraction.
// Assumes 1:1 prescale, so the base steps once per mclk.
`timescale 1ns/1ps
`default_nettype none
module pwm_timebase (
    input wire logic mclk,
    input wire logic run,
    input wire logic [7:0] period,
    output logic [7:0] count,
    output logic [1:0] frac,
    output logic clear
);
    logic [9:0] base_r;
    always_ff @(posedge mclk) begin
        if (!run || base_r == {period, 2'b11}) begin
            base_r <= 10'h000;
        end else begin
            base_r <= base_r + 10'h001;
        end
    end
    // Clear pulse in the cycle the base restarts
    assign {count, frac} = base_r;
    assign clear = run && base_r == 10'h000;
endmodule
`default_nettype wire

// ### src/pwm_dual.sv
// Dual pulse-width modulator: registers, timer selection, pins.
// Assumes external timers give count, fraction, period and a
// one-cycle clear pulse, all on mclk.
`timescale 1ns/1ps
`default_nettype none
module pwm_dual (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic por_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic [7:0] timer2_count,
    input wire logic [1:0] timer2_frac,
    input wire logic [7:0] timer2_period,
    input wire logic timer2_clear,
    input wire logic [7:0] timer4_count,
    input wire logic [1:0] timer4_frac,
    input wire logic [7:0] timer4_period,
    input wire logic timer4_clear,
    output logic [1:0] pwm_level,
    output logic [1:0] primary_pin_out,
    output logic [1:0] primary_pin_oe,
    output logic [7:0] extra_pin_out,
    output logic [7:0] extra_pin_oe
);
    // Shared registers
    logic [7:0] tsel_r;
    logic [7:0] rdata_r;
    logic [7:0] read_mux;
    logic tsel_hit;

    // Per-channel signals, index by channel
    logic [7:0] ctrl_rd [2];
    logic [7:0] extra_rd [2];
    logic [7:0] hi_rd [2];
    logic [7:0] lo_rd [2];
    logic [1:0] sel_bits;

    // Time-base views of both timers
    logic [9:0] t2_base;
    logic [9:0] t4_base;

    assign t2_base = {timer2_count, timer2_frac};
    assign t4_base = {timer4_count, timer4_frac};

    // Timer select bits per channel
    // first channel select
    assign sel_bits[0] = tsel_r[pwm_pkg::TSEL_CH1_BIT];
    assign sel_bits[1] = tsel_r[pwm_pkg::TSEL_CH2_BIT];

    // Timer select register decode
    assign tsel_hit = (addr == pwm_pkg::IDX_TSEL);

    // Timer select register, other bits read zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tsel_r <= pwm_pkg::TSEL_RST;
        end else if (wr_stb && tsel_hit) begin
            tsel_r <= wdata & 8'h05;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            logic [3:0] base;
            logic hit;
            logic [1:0] idx;
            logic wr_ctrl;
            logic wr_extra;
            logic wr_hi;
            logic wr_lo;
            logic en_r;
            logic oe_r;
            logic pol_r;
            logic [3:0] xoe_r;
            logic [9:0] duty;
            logic [9:0] count;
            logic [7:0] period;
            logic restart;
            logic level;
            logic active;
            logic pin_r;
            logic pin_oe_r;
            logic [3:0] xpin_r;
            logic [3:0] xoe_pin_r;
            logic flag;

            // Address decode for this channel
            assign base = 4'(ch) * pwm_pkg::CH_STRIDE;
            assign hit = (addr[3:2] == base[3:2]);
            assign idx = addr[1:0];
            assign wr_ctrl = wr_stb && hit &&
                (idx == pwm_pkg::IDX_CTRL);
            assign wr_extra = wr_stb && hit &&
                (idx == pwm_pkg::IDX_EXTRA);
            assign wr_hi = wr_stb && hit &&
                (idx == pwm_pkg::IDX_DUTY_HI);
            assign wr_lo = wr_stb && hit &&
                (idx == pwm_pkg::IDX_DUTY_LO);

            // Control and extra enable registers
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    en_r <= pwm_pkg::CTRL_RST[pwm_pkg::CTRL_EN_BIT];
                    oe_r <= pwm_pkg::CTRL_RST[pwm_pkg::CTRL_OE_BIT];
                    pol_r <= pwm_pkg::CTRL_RST[pwm_pkg::CTRL_POL_BIT];
                    xoe_r <= pwm_pkg::EXTRA_RST;
                end else begin
                    if (wr_ctrl) begin
                        en_r <= wdata[pwm_pkg::CTRL_EN_BIT];
                        oe_r <= wdata[pwm_pkg::CTRL_OE_BIT];
                        pol_r <= wdata[pwm_pkg::CTRL_POL_BIT];
                    end
                    if (wr_extra) begin
                        xoe_r <= wdata[3:0];
                    end
                end
            end

            // Duty registers kept across ordinary resets
            pwm_duty_store u_duty (
                .mclk(mclk),
                .por_n(por_n),
                .wr_hi(wr_hi),
                .wr_lo(wr_lo),
                .wdata(wdata),
                .duty_hi(hi_rd[ch]),
                .duty_lo(lo_rd[ch]),
                .duty(duty)
            );

            assign count = sel_bits[ch] ? t4_base : t2_base;
            assign period = sel_bits[ch] ? timer4_period :
                timer2_period;
            assign restart = sel_bits[ch] ? timer4_clear :
                timer2_clear;

            // compare core holds its output inactive unless enabled
            pwm_modulator u_mod (
                .mclk(mclk),
                .reset_n(reset_n),
                .enable(en_r),
                .polarity(pol_r),
                .restart(restart),
                .count(count),
                .period(period),
                .duty_in(duty),
                .level(level),
                .raw_active(active)
            );

            assign flag = en_r & level;

            // Pin registers
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    pin_r <= 1'b0;
                    pin_oe_r <= 1'b0;
                    xpin_r <= 4'h0;
                    xoe_pin_r <= 4'h0;
                end else begin
                    pin_r <= level;
                    // primary pin gated by bit 6
                    pin_oe_r <= oe_r;
                    xpin_r <= {4{level}};
                    xoe_pin_r <= xoe_r;
                end
            end

            // Register read views
            assign ctrl_rd[ch] = {en_r, oe_r, flag, pol_r, 4'h0};
            assign extra_rd[ch] = {4'h0, xoe_r};

            // Output ports of this channel
            assign pwm_level[ch] = level;
            assign primary_pin_out[ch] = pin_r;
            assign primary_pin_oe[ch] = pin_oe_r;
            assign extra_pin_out[ch*4 +: 4] = xpin_r;
            assign extra_pin_oe[ch*4 +: 4] = xoe_pin_r;
        end
    endgenerate

    // Read selection, unmapped reads zero
    always_comb begin
        read_mux = pwm_pkg::READ_ZERO;
        unique case (addr)
            4'h0: read_mux = ctrl_rd[0];
            4'h1: read_mux = extra_rd[0];
            4'h2: read_mux = hi_rd[0];
            4'h3: read_mux = lo_rd[0];
            4'h4: read_mux = ctrl_rd[1];
            4'h5: read_mux = extra_rd[1];
            4'h6: read_mux = hi_rd[1];
            4'h7: read_mux = lo_rd[1];
            4'h8: read_mux = tsel_r;
            default: read_mux = pwm_pkg::READ_ZERO;
        endcase
    end

    // Read data stands one cycle after the strobe only
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= pwm_pkg::READ_ZERO;
        end else begin
            rdata_r <= rd_stb ? read_mux : pwm_pkg::READ_ZERO;
        end
    end

    assign rdata = rdata_r;
endmodule
`default_nettype wire

// ### src/pwm_duty_store.sv
// Software-visible duty value of one channel.
// Assumes por_n is the power-on/brown-out reset only.
`timescale 1ns/1ps
`default_nettype none
module pwm_duty_store (
    input wire logic mclk,
    input wire logic por_n,
    input wire logic wr_hi,
    input wire logic wr_lo,
    input wire logic [7:0] wdata,
    output logic [7:0] duty_hi,
    output logic [7:0] duty_lo,
    output logic [9:0] duty
);
    logic [7:0] hi_r;
    logic [1:0] lo_r;

    always_ff @(posedge mclk or negedge por_n) begin
        if (!por_n) begin
            hi_r <= pwm_pkg::DUTY_HI_RST;
            lo_r <= pwm_pkg::DUTY_LO_RST;
        end else begin
            if (wr_hi) begin
                hi_r <= wdata;
            end
            if (wr_lo) begin
                lo_r <= wdata[7:pwm_pkg::DUTY_LO_POS];
            end
        end
    end

    assign duty_hi = hi_r;
    assign duty_lo = {lo_r, 6'h00};
    assign duty = {hi_r, lo_r};
endmodule
`default_nettype wire

// ### src/pwm_modulator.sv
// Compare core of one channel: buffered duty against the time base.
// Assumes restart pulses in the cycle the timer clears.
`timescale 1ns/1ps
`default_nettype none
module pwm_modulator (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic polarity,
    input wire logic restart,
    input wire logic [9:0] count,
    input wire logic [7:0] period,
    input wire logic [9:0] duty_in,
    output logic level,
    output logic raw_active
);
    logic [9:0] buf_r;
    logic [9:0] buf_nxt;
    logic active_r;
    logic active_nxt;
    logic [10:0] full_limit;
    logic full_duty;
    logic match;

    assign buf_nxt = restart ? duty_in : buf_r;
    // duty at or beyond period never clears
    assign full_limit = {1'b0, period, 2'b00} + pwm_pkg::PERIOD_STEP;
    assign full_duty = {1'b0, buf_nxt} >= full_limit;
    assign match = (count == buf_nxt) && !full_duty;

    // set on restart, zero duty stays off
    always_comb begin
        if (!enable) begin
            active_nxt = 1'b0;
        end else if (restart) begin
            active_nxt = (duty_in != 10'h000);
        end else if (match) begin
            active_nxt = 1'b0;
        end else begin
            active_nxt = active_r;
        end
    end

    // Buffer and output state
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            buf_r <= 10'h000;
            active_r <= 1'b0;
        end else begin
            buf_r <= buf_nxt;
            active_r <= active_nxt;
        end
    end

    assign level = active_r ^ polarity;
    assign raw_active = active_r;
endmodule
`default_nettype wire

// ### src/pwm_pkg.sv
// Constants for the dual pulse-width modulator block.
// Assumes an 8-bit register port and external 8-bit timers.
package pwm_pkg;
    // Register port widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int NUM_CH = 2;
    localparam int NUM_EXTRA = 4;
    localparam int DUTY_W = 10;
    // Register indices, four per channel
    localparam logic [3:0] CH_STRIDE = 4'h4;
    localparam logic [1:0] IDX_CTRL = 2'h0;
    localparam logic [1:0] IDX_EXTRA = 2'h1;
    localparam logic [1:0] IDX_DUTY_HI = 2'h2;
    localparam logic [1:0] IDX_DUTY_LO = 2'h3;
    localparam logic [3:0] IDX_TSEL = 4'h8;
    // Control register fields
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OE_BIT = 6;
    localparam int CTRL_OUT_BIT = 5;
    localparam int CTRL_POL_BIT = 4;
    // Timer select fields, one bit per channel
    localparam int TSEL_CH1_BIT = 0;
    localparam int TSEL_CH2_BIT = 2;
    // Low duty register field
    localparam int DUTY_LO_POS = 6;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] TSEL_RST = 8'h00;
    localparam logic [3:0] EXTRA_RST = 4'h0;
    localparam logic [7:0] DUTY_HI_RST = 8'h00;
    localparam logic [1:0] DUTY_LO_RST = 2'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // Count added to the period for a full-duty check
    localparam logic [10:0] PERIOD_STEP = 11'h004;
endpackage
